/* hw/asf_pkg.sv */
// constants, types and rule summary for the serial frame interface of the converter
//
// What this block does
// - serial clock is both conversion clock and bit clock of every frame.
// - chip select fall holds the sample, starts conversion, enables the output driver.
// - a frame takes 16 serial clocks; host supplies all of them.
// - track-and-hold returns to tracking on falling edge 14 of a normal frame.
// - a sequence word frame keeps hold until chip select rises.
// - weak-hold bit 0 releases the output to high impedance on edge 16.
// - output frame is four channel bits, top first, then 12 result bits.
// - top channel bit shows at select fall; each later edge launches next bit.
// - last result bit launched on edge 15, valid at edge 16.
// - write flag 1 captures control word over first 12 edges, except in a sequence word frame; else unchanged.
// - sequence-word selection captures all 16 input bits of the following frame.
// - sequence word commits at select rise; first selected channel then tracked.
// - weak-hold bit 1 keeps output weakly driven with next frame's top channel bit.
// - weak drive may be overridden by another driver without contention.
// - power code 01 is auto shutdown, 00 auto standby, low power between conversions.
// - power code 11 stays fully powered; 10 is full shutdown until rewritten.
// - auto modes wake on select fall, need 1 us; host runs one dummy frame.
package asf_pkg;

	// ************************************************************
	// frame geometry
	// ************************************************************
	localparam int         CNT_W         = 5;
	localparam int         CTRL_W        = 12;
	localparam int         SEQ_W         = 16;
	localparam int         RES_W         = 12;
	localparam int         CHAN_W        = 4;
	localparam logic [4:0] FRAME_EDGES   = 5'h10;
	localparam logic [4:0] LAST_BIT_EDGE = 5'h0f;
	localparam logic [4:0] TRACK_EDGE    = 5'h0e;
	localparam logic [4:0] CTRL_EDGES    = 5'h0c;
	localparam logic [4:0] ID_EDGES      = 5'h04;
	localparam logic [4:0] RES_LOAD_CNT  = 5'h02;

	// ************************************************************
	// control word fields, write flag is the first bit shifted in
	// ************************************************************
	localparam int CW_WRITE   = 11;
	localparam int CW_SEQ_USE = 10;
	localparam int CW_ADDR_HI = 9;
	localparam int CW_ADDR_LO = 6;
	localparam int CW_PM_HI   = 5;
	localparam int CW_PM_LO   = 4;
	localparam int CW_SHADOW  = 3;
	localparam int CW_WEAK    = 2;

	localparam logic [11:0] CTRL_RST = 12'h030;
	localparam logic [15:0] SEQ_RST  = 16'h0000;

	// power_mode_high_bit, power_mode_low_bit codes
	localparam logic [1:0] PM_NORMAL  = 2'h3;
	localparam logic [1:0] PM_FULL    = 2'h2;
	localparam logic [1:0] PM_AUTO_SD = 2'h1;
	localparam logic [1:0] PM_AUTO_SB = 2'h0;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int WAKE_NS  = 1000;
	localparam int CORE_NS  = 5;
	localparam int WAKE_CYC = (WAKE_NS + CORE_NS - 1) / CORE_NS;

	typedef enum logic [3:0] {
		PW_ON   = 4'h1,
		PW_WAKE = 4'h2,
		PW_LOW  = 4'h4,
		PW_OFF  = 4'h8
	} asf_pwr_t;

	typedef struct packed {
		logic [11:0] ctrl;
		logic [15:0] sr;
		logic [15:0] seq;
		logic [3:0]  chan;
		logic [3:0]  fchan;
		logic [11:0] res;
		logic        dout;
		logic        shadow_next;
		logic        sh_frame;
		logic        seq_pend;
		logic        seq_on;
		logic        ctrl_tgl;
		logic        seq_tgl;
		logic        done_tgl;
	} asf_link_t;

	typedef struct packed {
		logic        cs_q;
		logic        ct_q;
		logic        sq_q;
		logic        dn_q;
		logic [11:0] ctrl;
		logic [15:0] seq_hold;
		logic        seq_new;
		logic [15:0] seq;
		logic        done;
		asf_pwr_t    pstate;
		logic [7:0]  wcnt;
	} asf_core_t;

endpackage

/* hw/asf_sync.sv */
// two-flop level synchroniser into the core clock
`timescale 1ns/1ps
module asf_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} asf_sync_t;

	asf_sync_t st_r;
	asf_sync_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= {RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule // asf_sync

/* hw/asf_serial_if.sv */
// serial frame engine on the link clock plus power sequencing on the core clock
`timescale 1ns/1ps
module asf_serial_if
	import asf_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYC
) (
	// clocks and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        sclk,
	// serial pins
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             dout_o,
	output logic             dout_oe_n,
	output logic             dout_weak,
	// converter core, link clock side
	input  wire logic [11:0] conv_result,
	output logic             track_hold,
	output logic             sar_run,
	output logic [3:0]       conv_chan,
	// status, core clock side
	output logic [11:0]      ctrl_word,
	output logic [15:0]      seq_word,
	output logic [1:0]       power_mode,
	output logic             pwr_down,
	output logic             pwr_standby,
	output logic             awake
);

	if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255) begin : g_chk
		$error("WAKE_CYCLES must lie in 1..255");
	end

	// ************************************************************
	// helpers
	// ************************************************************
	// next set channel after start, wrapping; start itself if nothing else set
	function automatic logic [3:0] nxt_set(input logic [15:0] m, input logic [3:0] start);
		logic [3:0] idx;
		logic [3:0] r;
		logic       hit;
		r   = start;
		hit = 1'b0;
		for (int i = 1; i <= 16; i++) begin
			idx = start + 4'(i);
			if (!hit && m[idx]) begin
				r   = idx;
				hit = 1'b1;
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] upto(input logic [3:0] a);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			m[i] = (4'(i) <= a);
		end
		return m;
	endfunction

	// ************************************************************
	// link clock domain
	// ************************************************************
	asf_link_t   lnk_r;
	asf_link_t   lnk_nxt;
	logic [4:0]  cnt_r;
	logic [4:0]  edge_k;
	logic [3:0]  chan_now;
	logic [3:0]  fid;
	logic [15:0] fw;
	logic [3:0]  chan_after;
	logic        frame_drv;
	logic        weak_en;

	// edge counter cleared by the frame's own select, so nothing depends on idle clocks
	always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 5'h00;
		end else if (cs_n) begin
			cnt_r <= 5'h00;
		end else if (cnt_r < FRAME_EDGES) begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	// a committed sequence takes over the channel choice from edge 16 of its frame on
	assign chan_now = lnk_r.seq_pend ? nxt_set(lnk_r.seq, 4'hf) : lnk_r.chan;
	assign edge_k   = cnt_r + 5'h01;
	assign fid      = (cnt_r == 5'h00) ? chan_now : lnk_r.fchan;
	assign fw       = {fid, lnk_r.res};

	always_comb begin
		lnk_nxt    = lnk_r;
		chan_after = lnk_r.chan;
		if (!cs_n && cnt_r < FRAME_EDGES) begin
			lnk_nxt.sr = {lnk_r.sr[14:0], din};
			if (cnt_r == 5'h00) begin
				lnk_nxt.fchan       = chan_now;
				lnk_nxt.sh_frame    = lnk_r.shadow_next;
				lnk_nxt.shadow_next = 1'b0;
				if (lnk_r.seq_pend) begin
					lnk_nxt.seq_on   = 1'b1;
					lnk_nxt.seq_pend = 1'b0;
				end
			end
			// result is ready before its first bit goes out on edge 4
			if (cnt_r == RES_LOAD_CNT) begin
				lnk_nxt.res = conv_result;
			end
			if (edge_k < FRAME_EDGES) begin
				lnk_nxt.dout = fw[4'(LAST_BIT_EDGE - edge_k)];
			end
			if (edge_k == CTRL_EDGES && !lnk_nxt.sh_frame && lnk_nxt.sr[CW_WRITE]) begin
				lnk_nxt.ctrl     = lnk_nxt.sr[11:0];
				lnk_nxt.ctrl_tgl = ~lnk_r.ctrl_tgl;
			end
			if (edge_k == FRAME_EDGES) begin
				if (lnk_nxt.sh_frame) begin
					lnk_nxt.seq      = lnk_nxt.sr;
					lnk_nxt.seq_pend = 1'b1;
					lnk_nxt.seq_tgl  = ~lnk_r.seq_tgl;
				end else if (lnk_nxt.ctrl[CW_SHADOW] && !lnk_nxt.ctrl[CW_SEQ_USE]) begin
					lnk_nxt.shadow_next = 1'b1;
				end else if (lnk_nxt.ctrl[CW_SHADOW] && lnk_nxt.ctrl[CW_SEQ_USE]) begin
					lnk_nxt.seq      = upto(lnk_nxt.ctrl[CW_ADDR_HI:CW_ADDR_LO]);
					lnk_nxt.seq_pend = 1'b1;
					lnk_nxt.seq_tgl  = ~lnk_r.seq_tgl;
				end else if (!lnk_nxt.ctrl[CW_SEQ_USE]) begin
					lnk_nxt.seq_on   = 1'b0;
					lnk_nxt.seq_pend = 1'b0;
				end
				if (lnk_nxt.seq_on) begin
					lnk_nxt.chan = nxt_set(lnk_nxt.seq, lnk_nxt.fchan);
				end else begin
					lnk_nxt.chan = lnk_nxt.ctrl[CW_ADDR_HI:CW_ADDR_LO];
				end
				chan_after       = lnk_nxt.seq_pend ? nxt_set(lnk_nxt.seq, 4'hf) : lnk_nxt.chan;
				lnk_nxt.dout     = chan_after[3];
				lnk_nxt.done_tgl = ~lnk_r.done_tgl;
			end
		end
	end

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			lnk_r <= '{ctrl: CTRL_RST, seq: SEQ_RST, default: '0};
		end else begin
			lnk_r <= lnk_nxt;
		end
	end

	// ************************************************************
	// pins and converter controls
	// ************************************************************
	assign frame_drv  = !cs_n && (cnt_r < FRAME_EDGES);
	// weak drive is a separate strength flag so the pad can be overpowered
	assign weak_en    = lnk_r.ctrl[CW_WEAK] && !frame_drv;
	assign dout_oe_n  = !(frame_drv || weak_en);
	assign dout_weak  = weak_en;
	assign dout_o     = (cnt_r == 5'h00) ? chan_now[3] : lnk_r.dout;
	assign track_hold = !cs_n && ((cnt_r < TRACK_EDGE) || lnk_r.sh_frame);
	assign sar_run    = frame_drv;
	assign conv_chan  = lnk_r.fchan;

	// ************************************************************
	// core clock domain
	// ************************************************************
	logic [3:0] sy;
	asf_core_t  cor_r;
	asf_core_t  cor_nxt;
	logic       cs_rise;
	logic       cs_fall;
	logic       done_now;
	logic [1:0] pm;

	asf_sync #(
		.W       (4),
		.RST_VAL (4'h1)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.d        ({lnk_r.done_tgl, lnk_r.seq_tgl, lnk_r.ctrl_tgl, cs_n}),
		.q        (sy)
	);

	assign cs_rise = sy[0] && !cor_r.cs_q;
	assign cs_fall = !sy[0] && cor_r.cs_q;
	assign pm      = cor_r.ctrl[CW_PM_HI:CW_PM_LO];

	always_comb begin
		cor_nxt      = cor_r;
		cor_nxt.cs_q = sy[0];
		cor_nxt.ct_q = sy[1];
		cor_nxt.sq_q = sy[2];
		cor_nxt.dn_q = sy[3];
		done_now     = cor_r.done || (sy[3] != cor_r.dn_q);
		// link words are stable for a whole frame once their toggle arrives
		if (sy[1] != cor_r.ct_q) begin
			cor_nxt.ctrl = lnk_r.ctrl;
		end
		if (cs_rise && cor_r.seq_new) begin
			cor_nxt.seq     = cor_r.seq_hold;
			cor_nxt.seq_new = 1'b0;
		end
		if (sy[2] != cor_r.sq_q) begin
			cor_nxt.seq_hold = lnk_r.seq;
			cor_nxt.seq_new  = 1'b1;
		end
		if (cs_rise || cs_fall) begin
			cor_nxt.done = 1'b0;
		end
		if (sy[3] != cor_r.dn_q) begin
			cor_nxt.done = 1'b1;
		end
		case (cor_r.pstate)
			PW_ON: begin
				if (cs_rise && done_now) begin
					if (pm == PM_FULL) begin
						cor_nxt.pstate = PW_OFF;
					end else if (pm == PM_AUTO_SD || pm == PM_AUTO_SB) begin
						cor_nxt.pstate = PW_LOW;
					end
				end
			end
			PW_LOW: begin
				if (cs_fall) begin
					cor_nxt.pstate = PW_WAKE;
					cor_nxt.wcnt   = 8'h00;
				end
			end
			PW_WAKE: begin
				cor_nxt.wcnt = cor_r.wcnt + 8'h01;
				if (cor_r.wcnt == 8'(WAKE_CYCLES - 1)) begin
					cor_nxt.pstate = PW_ON;
				end
			end
			PW_OFF: begin
				// only a rewrite of the power code lifts full shutdown
				if (cs_rise && pm != PM_FULL) begin
					cor_nxt.pstate = PW_WAKE;
					cor_nxt.wcnt   = 8'h00;
				end
			end
			default: begin
				cor_nxt.pstate = PW_ON;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cor_r <= '{cs_q: 1'b1, ctrl: CTRL_RST, seq: SEQ_RST, pstate: PW_ON, default: '0};
		end else begin
			cor_r <= cor_nxt;
		end
	end

	assign ctrl_word   = cor_r.ctrl;
	assign seq_word    = cor_r.seq;
	assign power_mode  = pm;
	assign pwr_down    = (cor_r.pstate == PW_LOW) || (cor_r.pstate == PW_OFF);
	assign pwr_standby = (cor_r.pstate == PW_LOW) && (pm == PM_AUTO_SB);
	assign awake       = (cor_r.pstate == PW_ON);

	// ************************************************************
	// checks, link clock
	// ************************************************************
	// link clock stops between frames: the rising edge after edge 16 is the last one seen in a frame
	a_edge_count: assert property (@(posedge sclk) disable iff (!rst_n)
		(!cs_n && cnt_r < FRAME_EDGES) |=> (cs_n || cnt_r == $past(cnt_r) + 5'h01))
		else $error("edge counter did not advance");

	a_ctrl_write: assert property (@(negedge sclk) disable iff (!rst_n)
		(!cs_n && cnt_r == CTRL_EDGES && $past(cnt_r) == 5'h0b && !lnk_r.sh_frame && lnk_r.sr[CW_WRITE])
		|-> lnk_r.ctrl == lnk_r.sr[11:0])
		else $error("control word not captured on edge 12");

	a_ctrl_keep: assert property (@(negedge sclk) disable iff (!rst_n)
		(!cs_n && cnt_r == CTRL_EDGES && $past(cnt_r) == 5'h0b && !lnk_r.sr[CW_WRITE])
		|-> $stable(lnk_r.ctrl))
		else $error("control word changed without write flag");

	a_track_edge: assert property (@(negedge sclk) disable iff (!rst_n)
		(!cs_n && cnt_r >= TRACK_EDGE && !lnk_r.sh_frame) |-> !track_hold)
		else $error("still holding after edge 14");

	a_shadow_hold: assert property (@(negedge sclk) disable iff (!rst_n)
		(!cs_n && lnk_r.sh_frame && cnt_r != 5'h00) |-> track_hold)
		else $error("sequence frame released hold early");

	a_oe_release: assert property (@(posedge sclk) disable iff (!rst_n)
		(!cs_n && cnt_r == FRAME_EDGES && !lnk_r.ctrl[CW_WEAK]) |-> dout_oe_n)
		else $error("output still driven after edge 16");

	a_weak_drive: assert property (@(posedge sclk) disable iff (!rst_n)
		(!cs_n && cnt_r == FRAME_EDGES && lnk_r.ctrl[CW_WEAK])
		|-> (!dout_oe_n && dout_weak && dout_o == chan_now[3]))
		else $error("weak hold not showing next top channel bit");

	a_id_bits: assert property (@(negedge sclk) disable iff (!rst_n)
		(!cs_n && cnt_r == 5'h01) |-> (dout_o == lnk_r.fchan[2]) ##1 (cs_n || dout_o == lnk_r.fchan[1])
		##1 (cs_n || dout_o == lnk_r.fchan[0]))
		else $error("channel bits out of order");

	a_last_bit: assert property (@(negedge sclk) disable iff (!rst_n)
		(!cs_n && cnt_r == LAST_BIT_EDGE) |-> dout_o == lnk_r.res[0] && !dout_oe_n)
		else $error("last result bit not on edge 15");

	// ************************************************************
	// checks, core clock
	// ************************************************************
	a_wake_time: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(awake) && $past(cor_r.pstate) == PW_WAKE |-> $past(cor_r.wcnt) == 8'(WAKE_CYCLES - 1))
		else $error("woke before wake time");

	a_full_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cor_r.pstate == PW_OFF && pm == PM_FULL) |=> cor_r.pstate == PW_OFF)
		else $error("left full shutdown without rewrite");

	a_auto_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cor_r.pstate == PW_ON && cs_rise && done_now && (pm == PM_AUTO_SD || pm == PM_AUTO_SB))
		|=> pwr_down)
		else $error("auto mode did not drop to low power");

	c_ctrl_write: cover property (@(negedge sclk) disable iff (!rst_n)
		!cs_n && cnt_r == CTRL_EDGES && lnk_r.sr[CW_WRITE] && !lnk_r.sh_frame);
	c_seq_frame: cover property (@(posedge sclk) disable iff (!rst_n)
		!cs_n && cnt_r == FRAME_EDGES && lnk_r.sh_frame);
	c_wake_done: cover property (@(posedge core_clk) disable iff (!rst_n)
		$past(cor_r.pstate) == PW_WAKE && awake);
endmodule // asf_serial_if

/* verif/asf_host_model.sv */
// host serial port model: drives select, link clock and serial input, captures serial output
`timescale 1ns/1ps
module asf_host_model (
	// link pins driven by the host
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	// device output pad
	input  wire logic dout_o,
	input  wire logic dout_oe_n
);
	localparam time HALF = 6ns;

	logic last_v;
	logic pad;

	// ************************************************************
	// pad level
	// ************************************************************
	// a released pad has no pull: show the inverse of its last level, never a stale copy
	always @* begin
		if (!dout_oe_n) begin
			last_v = dout_o;
		end
	end
	assign pad = dout_oe_n ? ~last_v : dout_o;

	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end

	// ************************************************************
	// one full frame; link clock stands high outside frames
	// ************************************************************
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		din  = tx[15];
		cs_n = 1'b0;
		#HALF;
		for (int i = 0; i < 16; i++) begin
			rx[15 - i] = pad;
			sclk       = 1'b0;
			#HALF;
			sclk = 1'b1;
			din  = (i < 15) ? tx[14 - i] : ~din;
			#HALF;
		end
		cs_n = 1'b1;
	endtask
endmodule // asf_host_model

/* verif/asf_serial_if_bench.sv */
// self-checking bench for the serial frame interface, driven through the host model
`timescale 1ns/1ps
module asf_serial_if_bench
	import asf_pkg::*;
;
	localparam int WAKE_T = 8;

	// ************************************************************
	// signals and instances
	// ************************************************************
	logic        core_clk;
	logic        rst_n;
	logic        sclk;
	logic        cs_n;
	logic        din;
	logic        dout_o;
	logic        dout_oe_n;
	logic        dout_weak;
	logic [11:0] conv_result;
	logic        track_hold;
	logic        sar_run;
	logic [3:0]  conv_chan;
	logic [11:0] ctrl_word;
	logic [15:0] seq_word;
	logic [1:0]  power_mode;
	logic        pwr_down;
	logic        pwr_standby;
	logic        awake;
	int          err_total = 0;
	int          checked   = 0;

	asf_serial_if #(.WAKE_CYCLES(WAKE_T)) i_asf_serial_if (
		.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout_o(dout_o), .dout_oe_n(dout_oe_n), .dout_weak(dout_weak),
		.conv_result(conv_result), .track_hold(track_hold), .sar_run(sar_run),
		.conv_chan(conv_chan), .ctrl_word(ctrl_word), .seq_word(seq_word),
		.power_mode(power_mode), .pwr_down(pwr_down), .pwr_standby(pwr_standby), .awake(awake)
	);

	asf_host_model i_asf_host_model (
		.sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n)
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic close_out;
		if (err_total == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk_w(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_b(input string what, input logic exp, input logic got);
		chk_w(what, {15'h0, exp}, {15'h0, got});
	endtask

	// 16 core cycles cover sync plus the shortened wake count
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		i_asf_host_model.frame(tx, rx);
		repeat (16) @(posedge core_clk);
		#1;
	endtask

	task automatic watch(input logic hold14);
		// the frame may already have begun in this time step
		if (cs_n) begin
			@(negedge cs_n);
		end
		#1;
		chk_b("oe_n at select", 1'b0, dout_oe_n);
		chk_b("hold at select", 1'b1, track_hold);
		chk_b("busy at select", 1'b1, sar_run);
		repeat (13) @(negedge sclk);
		#1;
		chk_b("hold at edge 13", 1'b1, track_hold);
		@(negedge sclk);
		#1;
		chk_b("hold at edge 14", hold14, track_hold);
		repeat (2) @(negedge sclk);
		#1;
		chk_b("hold at edge 16", hold14, track_hold);
		chk_b("busy after 16", 1'b0, sar_run);
	endtask

	task automatic frame_w(input logic [15:0] tx, input logic hold14, output logic [15:0] rx);
		fork
			watch(hold14);
			xfer(tx, rx);
		join
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		chk_w("ctrl reset", {4'h0, CTRL_RST}, {4'h0, ctrl_word});
		chk_w("seq reset", SEQ_RST, seq_word);
		chk_b("awake reset", 1'b1, awake);
		chk_b("oe_n idle", 1'b1, dout_oe_n);
		chk_b("hold idle", 1'b0, track_hold);
	endtask

	task automatic t_read;
		logic [15:0] rx;
		conv_result = 12'h801;
		frame_w(16'h0000, 1'b0, rx);
		chk_w("read frame", 16'h0801, rx);
		chk_b("oe_n released", 1'b1, dout_oe_n);
	endtask

	task automatic t_write;
		logic [15:0] rx;
		conv_result = 12'h7fe;
		frame_w({12'h970, 4'h0}, 1'b0, rx);
		chk_w("write frame", 16'h07fe, rx);
		chk_w("ctrl written", 16'h0970, {4'h0, ctrl_word});
		// write flag low: the remaining ones must not land
		frame_w(16'h7fff, 1'b0, rx);
		chk_w("chan 5 frame", 16'h57fe, rx);
		chk_w("ctrl kept", 16'h0970, {4'h0, ctrl_word});
	endtask

	task automatic t_weak;
		logic [15:0] rx;
		frame_w({12'ha34, 4'h0}, 1'b0, rx);
		frame_w(16'h0000, 1'b0, rx);
		chk_w("chan 8 frame", 16'h87fe, rx);
		chk_b("weak oe_n", 1'b0, dout_oe_n);
		chk_b("weak flag", 1'b1, dout_weak);
		chk_b("weak top bit", 1'b1, dout_o);
	endtask

	task automatic t_power;
		logic [15:0] rx;
		logic [11:0] cw [3];
		cw = '{12'h810, 12'h800, 12'h820};
		for (int k = 0; k < 3; k++) begin
			xfer({cw[k], 4'h0}, rx);
			chk_w("power code", {14'h0, cw[k][5:4]}, {14'h0, power_mode});
			chk_b("low power", 1'b1, pwr_down);
			chk_b("standby", k == 1, pwr_standby);
			chk_b("not awake", 1'b0, awake);
			// dummy frame with write flag low wakes only the auto modes, then they drop again
			fork
				xfer(16'h0000, rx);
				begin
					if (cs_n) begin
						@(negedge cs_n);
					end
					repeat (WAKE_T + 8) @(posedge core_clk);
					#1;
					chk_b("awake in dummy", k != 2, awake);
				end
			join
			chk_b("low after dummy", 1'b1, pwr_down);
			xfer({12'h830, 4'h0}, rx);
			chk_b("normal again", 1'b1, awake);
			chk_b("no low power", 1'b0, pwr_down);
		end
	endtask

	task automatic t_shadow;
		logic [15:0] rx;
		frame_w({12'h838, 4'h0}, 1'b0, rx);
		// first bit high: must not be taken as a control write
		frame_w(16'h8a00, 1'b1, rx);
		chk_b("track after rise", 1'b0, track_hold);
		chk_w("seq committed", 16'h8a00, seq_word);
		chk_w("ctrl untouched", 16'h0838, {4'h0, ctrl_word});
		frame_w(16'h0000, 1'b0, rx);
		chk_w("first seq chan", 16'h0009, {12'h0, rx[15:12]});
		chk_w("frame chan", 16'h0009, {12'h0, conv_chan});
	endtask

	// follows t_shadow, whose last frame leaves the next one a sequence-word frame
	task automatic t_sequence;
		logic [15:0] rx;
		frame_w(16'h0006, 1'b1, rx);
		chk_w("seq word 2", 16'h0006, seq_word);
		frame_w({12'hc30, 4'h0}, 1'b0, rx);
		chk_w("seq chan a", 16'h0001, {12'h0, rx[15:12]});
		frame_w(16'h0000, 1'b0, rx);
		chk_w("seq chan b", 16'h0002, {12'h0, rx[15:12]});
		frame_w({12'hcb8, 4'h0}, 1'b0, rx);
		chk_w("seq chan wrap", 16'h0001, {12'h0, rx[15:12]});
		chk_w("range seq", 16'h0007, seq_word);
		frame_w(16'h0000, 1'b0, rx);
		chk_w("range first", 16'h0000, {12'h0, rx[15:12]});
	endtask

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		rst_n       = 1'b0;
		conv_result = 12'h000;
		repeat (2) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		t_reset;
		t_read;
		t_write;
		t_weak;
		t_power;
		t_shadow;
		t_sequence;
		close_out;
	end

	// 22 frames of about 0.28 us each; about three times margin
	initial begin
		#20us;
		err_total++;
		close_out;
	end
endmodule // asf_serial_if_bench
